// [common/gdf_pkg.sv]
/*
 * Constants for the Gaussian decimation filter: clock ratios, filter
 * coefficient, datapath scaling, output coding and sequencer states.
 * Assumes one master clock drives all logic; every rate is a ratio of it.
 */
// Operation
// - Corner frequency is master clock over 409600
// - Output words at clock over 1024, 4 kHz
// - Six-pole Gaussian-like magnitude response
// - Strong 60 Hz rejection from six poles
// - Step settles monotonically within 125 ms
// - Continuous sampling, 16-bit register refreshed every word
// - Output register readable any time, undisturbed filtering
// - Datapath headroom covers 100 mV overrange
// - All rates fixed ratios of master clock
// - Select low unipolar, high bipolar range
// - Straight binary unipolar, offset binary bipolar
// - Codes zero at bottom, ones at top
// - LSB equals span over 65536
// - Modulator sampled every 256 master clocks
package gdf_pkg;

    // Clock ratios
    localparam int SAMPLE_DIV  = 256;               // Master clocks per modulator sample
    localparam int WORD_DIV    = 1024;              // Master clocks per output word
    localparam int DECIM       = WORD_DIV / SAMPLE_DIV;
    localparam int CORNER_DIV  = 409600;            // Master clocks per corner-frequency cycle
    localparam int STAGES      = 6;                 // Real poles in cascade

    // Reference master clock and settling time
    localparam int MCLK_REF_HZ = 4096000;
    localparam int SETTLE_MS   = 125;
    localparam int SETTLE_WORDS = (SETTLE_MS * (MCLK_REF_HZ / 1000)) / WORD_DIV;

    // Per-pole coefficient, Q16: 2*pi*(fs/CORNER_DIV... ) per pole, cascade of six gives the corner
    localparam int          ALPHA_SHIFT = 16;
    localparam logic [16:0] ALPHA_Q16   = 17'h002DF;

    // Datapath: full scale maps to +/-2^23, modulator extremes sit 4 % beyond
    localparam int                 ACC_W    = 28;
    localparam int                 CODE_W   = 16;
    localparam logic signed [27:0] IN_MAG   = 28'sh0851EB8;
    localparam int                 UNI_SHIFT = 7;
    localparam int                 BIP_SHIFT = 8;
    localparam logic signed [27:0] UNI_ROUND = 28'sh0000040;
    localparam logic signed [27:0] BIP_ROUND = 28'sh0000080;
    localparam logic signed [27:0] CODE_OFFSET = 28'sh0008000;
    localparam logic signed [27:0] CODE_TOP    = 28'sh000FFFF;
    localparam logic signed [27:0] ACC_ZERO    = 28'sh0000000;
    localparam logic [15:0]        CODE_MAX    = 16'hFFFF;
    localparam logic [15:0]        CODE_MIN    = 16'h0000;

    // Sequencer states, Gray along wait -> filter -> load
    typedef enum logic [1:0] {
        ST_WAIT = 2'b00,
        ST_FILT = 2'b01,
        ST_LOAD = 2'b11
    } seq_state_t;

endpackage

// [hw/gaussian_decimation_filter.sv]
/*
 * Gaussian decimation filter: samples a one-bit modulator stream, runs six
 * cascaded real poles time-shared on one multiplier, decimates by four and
 * loads a clamped 16-bit code into the output register.
 * Assumes the modulator bit and the range select are synchronous to the
 * master clock, and that the modulator updates its bit on the sample strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module gaussian_decimation_filter #(
    parameter int SETTLE_WORDS = gdf_pkg::SETTLE_WORDS
) (
    // Clock and reset
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RSTN,
    // Modulator side
    input  wire logic        i_mod_bit,
    output logic             o_sample_strobe,
    // Range control
    input  wire logic        i_range_polarity_select,
    // Output word
    output logic [15:0]      o_data,
    output logic             o_data_update,
    output logic             o_settled
);

    localparam int DIV_W = $clog2(gdf_pkg::SAMPLE_DIV);
    localparam int DEC_W = $clog2(gdf_pkg::DECIM);
    localparam int IDX_W = $clog2(gdf_pkg::STAGES);
    localparam int SET_W = $clog2(SETTLE_WORDS + 1);
    localparam int PROD_W = gdf_pkg::ACC_W + $bits(gdf_pkg::ALPHA_Q16); // Full product, no bits lost

    gdf_pkg::seq_state_t state;
    gdf_pkg::seq_state_t next_state;

    logic [DIV_W-1:0]                      div_cnt;
    logic [DEC_W-1:0]                      dec_cnt;
    logic [IDX_W-1:0]                      stage_idx;
    logic [SET_W-1:0]                      settle_cnt;
    logic signed [gdf_pkg::ACC_W-1:0]      x_in;
    logic signed [gdf_pkg::ACC_W-1:0]      pole [gdf_pkg::STAGES];

    // Sample timing, fixed ratio of master clock
    wire logic sample_now = (div_cnt == DIV_W'(0));
    wire logic last_stage = (stage_idx == IDX_W'(gdf_pkg::STAGES - 1));
    wire logic last_sample = (dec_cnt == DEC_W'(gdf_pkg::DECIM - 1));

    assign o_sample_strobe = sample_now;

    // One pole update: y += alpha * (in - y)
    wire logic signed [gdf_pkg::ACC_W-1:0] stage_in =
        (stage_idx == IDX_W'(0)) ? x_in : pole[stage_idx - IDX_W'(1)];
    wire logic signed [gdf_pkg::ACC_W-1:0] diff = stage_in - pole[stage_idx];
    wire logic signed [PROD_W-1:0] prod = diff * $signed(gdf_pkg::ALPHA_Q16);
    wire logic signed [gdf_pkg::ACC_W-1:0] step = prod[gdf_pkg::ALPHA_SHIFT +: gdf_pkg::ACC_W];

    // Code conversion: bipolar adds mid offset, unipolar doubles gain
    wire logic signed [gdf_pkg::ACC_W-1:0] y_final = pole[gdf_pkg::STAGES - 1];
    wire logic signed [gdf_pkg::ACC_W-1:0] bip_val =
        ((y_final + gdf_pkg::BIP_ROUND) >>> gdf_pkg::BIP_SHIFT) + gdf_pkg::CODE_OFFSET;
    wire logic signed [gdf_pkg::ACC_W-1:0] uni_val =
        (y_final + gdf_pkg::UNI_ROUND) >>> gdf_pkg::UNI_SHIFT;
    wire logic signed [gdf_pkg::ACC_W-1:0] scaled =
        i_range_polarity_select ? bip_val : uni_val;
    wire logic under = (scaled < gdf_pkg::ACC_ZERO);
    wire logic over  = (scaled > gdf_pkg::CODE_TOP);
    wire logic [15:0] code = under ? gdf_pkg::CODE_MIN :
                             over  ? gdf_pkg::CODE_MAX : scaled[15:0];

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            gdf_pkg::ST_WAIT: begin
                if (sample_now) begin
                    next_state = gdf_pkg::ST_FILT;
                end
            end
            gdf_pkg::ST_FILT: begin
                if (last_stage) begin
                    next_state = last_sample ? gdf_pkg::ST_LOAD : gdf_pkg::ST_WAIT;
                end
            end
            gdf_pkg::ST_LOAD: begin
                next_state = gdf_pkg::ST_WAIT;
            end
            default: begin
                next_state = gdf_pkg::ST_WAIT;
            end
        endcase
    end

    // Free-running sample divider, no start command
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end

    // State, stage index and decimation count
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state     <= gdf_pkg::ST_WAIT;
            stage_idx <= '0;
            dec_cnt   <= '0;
        end else begin
            state <= next_state;
            if (state == gdf_pkg::ST_FILT) begin
                stage_idx <= last_stage ? IDX_W'(0) : stage_idx + IDX_W'(1);
                if (last_stage) begin
                    dec_cnt <= dec_cnt + DEC_W'(1); // Wraps after DECIM samples
                end
            end
        end
    end

    // Latch modulator bit as +/- input magnitude with overrange headroom
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            x_in <= gdf_pkg::ACC_ZERO;
        end else if (sample_now) begin
            x_in <= i_mod_bit ? gdf_pkg::IN_MAG : -gdf_pkg::IN_MAG;
        end
    end

    // Pole states, one updated per clock, cascade gives no overshoot
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            for (int i = 0; i < gdf_pkg::STAGES; i++) begin
                pole[i] <= gdf_pkg::ACC_ZERO;
            end
        end else if (state == gdf_pkg::ST_FILT) begin
            pole[stage_idx] <= pole[stage_idx] + step;
        end
    end

    // Output register loaded whole in one edge, otherwise held
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            o_data        <= gdf_pkg::CODE_MIN;
            o_data_update <= 1'b0;
        end else begin
            o_data_update <= (state == gdf_pkg::ST_LOAD);
            if (state == gdf_pkg::ST_LOAD) begin
                o_data <= code;
            end
        end
    end

    // Settled after a settling time of words since reset
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            settle_cnt <= '0;
            o_settled  <= 1'b0;
        end else if (state == gdf_pkg::ST_LOAD && !o_settled) begin
            settle_cnt <= settle_cnt + SET_W'(1);
            o_settled  <= (settle_cnt == SET_W'(SETTLE_WORDS - 1));
        end
    end

endmodule

`default_nettype wire

// [bench/gdf_modulator.sv]
/* Modulator stand-in giving a steady all-ones or all-zeros stream.
   Assumes the filter samples the bit on the strobe edge. */
`timescale 1ns/1ps
`default_nettype none
module gdf_modulator (
    input  wire logic clk,
    input  wire logic strobe,
    input  wire logic level,
    output logic      bit_out
);
    // New bit just after each sample edge, steady between samples
    initial bit_out = 1'b0;
    always @(posedge clk) if (strobe) bit_out <= level;
endmodule
`default_nettype wire

// [bench/gaussian_decimation_filter_chk.sv]
/* Checker for sample and word cadence, word loads, reset state and settling.
   Assumes one clock domain, strobe high during reset. */
`timescale 1ns/1ps
`default_nettype none
module gaussian_decimation_filter_chk #(parameter int SETTLE_WORDS = 4) (
    input wire logic        I_CLK_SYS,
    input wire logic        I_RSTN,
    input wire logic        o_sample_strobe,
    input wire logic [15:0] o_data,
    input wire logic        o_data_update,
    input wire logic        o_settled
);
    logic [7:0]  scnt;
    logic [9:0]  wcnt;
    logic [15:0] ucnt;
    logic        seen;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RSTN);
    // Cycles since strobe and word, words since reset
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            scnt <= 8'h00;
            wcnt <= 10'h000;
            ucnt <= 16'h0000;
            seen <= 1'b0;
        end else begin
            scnt <= scnt + 8'h01;
            wcnt <= o_data_update ? 10'h000 : wcnt + 10'h001;
            ucnt <= ucnt + {15'h0000, o_data_update};
            seen <= seen | o_data_update;
        end
    end
    strobe_period_a: assert property (o_sample_strobe == (scnt == 8'h00)) else $error("strobe cadence");
    word_period_a: assert property (o_data_update && seen |-> wcnt == 10'h3FF) else $error("word cadence");
    load_edge_a: assert property (!$stable(o_data) |-> o_data_update) else $error("stray change");
    load_phase_a: assert property (o_data_update |-> $past(o_sample_strobe, 8)) else $error("load phase");
    update_pulse_a: assert property (o_data_update |=> !o_data_update [*8]) else $error("long pulse");
    settled_hold_a: assert property (o_settled |=> o_settled) else $error("settled fell");
    settled_count_a: assert property (ucnt > SETTLE_WORDS |-> o_settled) else $error("settled late");
    reset_clear_a: assert property (!$past(I_RSTN) |-> o_data == 16'h0000 && !o_settled) else $error("reset");
    cover property (o_data_update && o_data == 16'h0000);
    cover property (o_data_update && o_data == 16'h8000);
    cover property ($rose(o_settled));
endmodule
bind gaussian_decimation_filter gaussian_decimation_filter_chk #(.SETTLE_WORDS(SETTLE_WORDS)) u_chk (
    .I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .o_sample_strobe(o_sample_strobe),
    .o_data(o_data), .o_data_update(o_data_update), .o_settled(o_settled));
`default_nettype wire

// [bench/test_gaussian_decimation_filter.sv]
/* Bench: resets, drives range select and stream level, checks words from a queue.
   Assumes a 50 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module test_gaussian_decimation_filter;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        level = 1'b0;
    logic        sel = 1'b0;
    logic        mbit, strobe, upd, settled;
    logic [15:0] data;
    logic [15:0] prev = 16'h0000;
    logic [17:0] note;
    logic [17:0] note_q[$];
    int          err_count = 0;
    int          num_checks = 0;
    always #10 clk = ~clk;
    gaussian_decimation_filter #(.SETTLE_WORDS(4)) i_dut (.I_CLK_SYS(clk), .I_RSTN(rstn), .i_mod_bit(mbit),
        .o_sample_strobe(strobe), .i_range_polarity_select(sel), .o_data(data), .o_data_update(upd),
        .o_settled(settled));
    gdf_modulator i_mod (.clk(clk), .strobe(strobe), .level(level), .bit_out(mbit));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen, input logic ok);
        num_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Oldest note against each new word
    always @(negedge clk) begin
        if (upd === 1'b1 && note_q.size() > 0) begin
            note = note_q.pop_front();
            if (note[17:16] == 2'd0) check("word", note[15:0], data, data === note[15:0]);
            else if (note[17:16] == 2'd1) check("rising", prev, data, data >= prev);
            else check("ceiling", note[15:0], data, data <= note[15:0]);
            prev = data;
        end
    end
    // One phase from reset: stream level, range select, word count
    task automatic run(input logic lv, input logic s, input logic rnd, input int n);
        @(negedge clk);
        rstn = 1'b0;
        level = lv;
        repeat (5) @(negedge clk);
        check("reset", 16'h0000, data, data === 16'h0000 && upd === 1'b0 && settled === 1'b0);
        rstn = 1'b1;
        for (int i = 0; i < n; i++) begin
            sel = rnd ? 1'($urandom % 2) : s;
            note_q.push_back(lv ? (i == 0 ? {2'd0, s, 15'h0000} : 18'h10000) : (sel ? 18'h38000 : 18'h00000));
            @(negedge clk);
            for (int t = 0; t < 1100 && upd !== 1'b1; t++) @(negedge clk);
            // Reader trusts words only once the settling time has run
            if (i == 4) check("settled", 16'h0001, {15'h0000, settled}, settled === 1'b1);
        end
        @(negedge clk);
    endtask
    initial begin
        void'($urandom(10));
        run(1'b1, 1'b1, 1'b0, 20);
        check("rise", 16'h8000, data, data > 16'h8000);
        run(1'b1, 1'b0, 1'b0, 12);
        run(1'b0, 1'b0, 1'b1, 20);
        finish_test();
    end
    // Watchdog against a hung word cadence
    initial begin
        repeat (70000) @(posedge clk);
        err_count++;
        finish_test();
    end
endmodule
`default_nettype wire
